// ==== design/rip_pkg.sv ====
package rip_pkg;

	// Register byte offsets on the Wishbone slave.
	localparam logic [7:0] A_SYSCTL  = 8'h00;
	localparam logic [7:0] A_SYSSTAT = 8'h04;
	localparam logic [7:0] A_LMASK   = 8'h08;
	localparam logic [7:0] A_ST0     = 8'h0c;
	localparam logic [7:0] A_FLAG    = 8'h10;
	localparam logic [7:0] A_EN      = 8'h14;
	localparam logic [7:0] A_PLL     = 8'h18;
	localparam logic [7:0] A_IRQST   = 8'h1c;

	// Field positions.
	localparam int SC_CLR    = 14;
	localparam int SC_SET    = 15;
	localparam int CF_POR    = 15;
	localparam int CF_BAD    = 12;
	localparam int CF_SW     = 10;
	localparam int CF_WD     = 9;
	localparam int ST0_GMASK = 9;

	// Values after reset.
	localparam logic [1:0]  CTL_RST   = 2'h1;
	localparam logic [15:0] PLL_RST   = 16'h0000;
	localparam logic [15:0] CAUSE_RST = 16'h8000;

	// Vector locations.
	localparam logic [5:0] VEC_LINE1 = 6'h02;
	localparam logic [5:0] VEC_TRAP  = 6'h22;
	localparam logic [5:0] VEC_NMI   = 6'h24;

	// Cycle counts of the reset pin sequencer.
	localparam logic [3:0] STRETCH_CYC = 4'h8;
	localparam logic [3:0] BLANK_CYC   = 4'h4;

	// Pin positions in the synchroniser vector.
	localparam int NPIN    = 7;
	localparam int PIN_RS  = 0;
	localparam int PIN_POR = 1;
	localparam int PIN_NMI = 2;
	localparam int PIN_X1  = 3;
	localparam int PIN_X2  = 4;
	localparam int PIN_X3  = 5;
	localparam int PIN_PDP = 6;

	typedef enum logic [1:0] {OP_VCALL = 2'h0, OP_NMI = 2'h1, OP_TRAP = 2'h2} rip_op_t;
	typedef enum logic [1:0] {SQ_IDLE = 2'h0, SQ_DRIVE = 2'h1, SQ_BLANK = 2'h3} rip_seq_t;

	// Index of the lowest set bit, which is the highest priority.
	function automatic logic [2:0] rip_first(input logic [7:0] v);
		logic [2:0] f;
		f = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) f = 3'(i);
		end
		return f;
	endfunction : rip_first

endpackage : rip_pkg

// ==== design/rip_rst_if.sv ====
`timescale 1ns/100ps
interface rip_rst_if;
	logic trig;
	logic por_low;
	logic pin_low;
	logic drive;
	logic pin_o;
	logic por_act;
	modport seq (input trig, por_low, pin_low, output drive, pin_o, por_act);
	modport ctl (output trig, por_low, pin_low, input drive, pin_o, por_act);
endinterface : rip_rst_if

// ==== design/rip_rst_seq.sv ====
`timescale 1ns/100ps
module rip_rst_seq
	import rip_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// Reset request and pin drive.
	rip_rst_if.seq   rs
);

	rip_seq_t   state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic       again;

	// Our own drive echoes back on the pin, so the pin is only heard while idle.
	assign again = rs.trig | rs.por_low;

	// Sequencer next state.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			SQ_IDLE: begin
				if (again | rs.pin_low) begin
					state_d = SQ_DRIVE;
					cnt_d   = STRETCH_CYC - 4'h1;
				end
			end
			SQ_DRIVE: begin
				if (again) begin
					cnt_d = STRETCH_CYC - 4'h1;
				end else if (cnt_q == 4'h0) begin
					state_d = SQ_BLANK;
					cnt_d   = BLANK_CYC - 4'h1;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			SQ_BLANK: begin
				if (again) begin
					state_d = SQ_DRIVE;
					cnt_d   = STRETCH_CYC - 4'h1;
				end else if (cnt_q == 4'h0) begin
					state_d = SQ_IDLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			default: begin
				state_d = SQ_IDLE;
			end
		endcase
	end

	// RQ6: stretch pin drive
	// RQ7: hold while low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= SQ_IDLE;
			cnt_q      <= 4'h0;
			rs.drive   <= 1'b0;
			rs.pin_o   <= 1'b1;
			rs.por_act <= 1'b0;
		end else if (clk_en) begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			rs.drive   <= (state_d == SQ_DRIVE);
			rs.pin_o   <= (state_d != SQ_DRIVE);
			rs.por_act <= rs.por_low | (rs.por_act & (state_d == SQ_DRIVE));
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || !clk_en);

	property p_stretch;
		$rose(rs.drive) |-> rs.drive [*8];
	endproperty
	a_stretch: assert property (p_stretch) else $error("Reset pin drive shorter than eight cycles."); // RQ6

	property p_por_hold;
		rs.por_low |=> rs.drive && !rs.pin_o;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("Power-on pin low but reset not held."); // RQ7

	c_release: cover property ($fell(rs.drive));

endmodule : rip_rst_seq

// ==== design/rip_top.sv ====
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// RQ1: Watchdog overflow or bad watchdog write raises a system reset.
// RQ2: Writing zero to bit 14 or one to bit 15 of control resets.
// RQ3: Access to an illegal peripheral address raises a system reset.
// RQ4: Outside agent holds the reset pin low at least one clock; the pin filter needs it low on two successive clocks.
// RQ5: Outside agent holds the power-on pin low at least one clock; the pin filter needs it low on two successive clocks.
// RQ6: Any reset source drives the reset pin low at least eight clocks.
// RQ7: Reset persists while power-on pin or reset pin stays low.
// RQ8: Reset halts execution and restores control bits; memory untouched.
// RQ9: Only power-on reset clears the PLL control register.
// RQ10: Status holds cause flags at bits 15, 12, 10 and 9.
// RQ11: No reset clears the cause flags.
// RQ12: After any reset all maskable interrupts stay disabled.
// RQ13: External requests gated by enable and line mask; nonmaskable bypasses.
// RQ14: Nonmaskable request blocked only during its own service or reset.
// RQ15: Peripheral events gated by own enable and line mask.
// RQ16: Vector call branches to its operand and sets the global mask.
// RQ17: Nonmaskable instruction or pin branches to 24h and sets global mask.
// RQ18: Trap branches to 22h and leaves the global mask alone.
// RQ19: Lines ranked 1 to 10; highest pending taken first.
// RQ20: Reset 1, nonmaskable 3, maskable lines one to six at 4 to 9.
// RQ21: System module feeds lines one, five, six; event manager two to four.
// RQ22: Each line merges several sources by fixed priority.
// RQ23: Source flag set; enabled flags go to arbitration, winner to core.
// RQ24: Global mask bit 9 blocks maskables; set on take except trap, reset.
// RQ25: Cause flags set on detection, cleared only by software write.
module rip_top
	import rip_pkg::*;
#(
	parameter int NLINE = 6,
	parameter int NSRC  = 5
) (
	// Clock, reset and freeze.
	input  wire logic                   CLK_SYS,
	input  wire logic                   RST_N,
	input  wire logic                   CLK_EN,
	// Wishbone slave.
	input  wire logic                   WB_CYC_I,
	input  wire logic                   WB_STB_I,
	input  wire logic                   WB_WE_I,
	input  wire logic [7:0]             WB_ADR_I,
	input  wire logic [3:0]             WB_SEL_I,
	input  wire logic [31:0]            WB_DAT_I,
	output logic      [31:0]            WB_DAT_O,
	output logic                        WB_ACK_O,
	// Reset pins.
	input  wire logic                   EXT_RESET_PIN_N_I,
	output logic                        EXT_RESET_PIN_N_O,
	output logic                        EXT_RESET_PIN_OE,
	input  wire logic                   POWER_ON_RESET_PIN_N,
	// Internal reset sources.
	input  wire logic                   WDOG_OVERFLOW,
	input  wire logic                   WDOG_BAD_WRITE,
	input  wire logic                   BAD_ADDR_ACCESS,
	// Interrupt pins.
	input  wire logic                   NMI_PIN_N,
	input  wire logic                   EXT_IRQ_ONE_N,
	input  wire logic                   EXT_IRQ_TWO_N,
	input  wire logic                   EXT_IRQ_THREE_N,
	input  wire logic                   DRIVE_PROTECT_IRQ_N,
	// Peripheral source requests.
	input  wire logic [NLINE*NSRC-1:0]  PERIPH_IRQ,
	// Core side.
	input  wire logic                   CORE_READY,
	input  wire logic                   CORE_INSTR_VALID,
	input  wire logic [1:0]             CORE_INSTR_OP,
	input  wire logic [5:0]             CORE_INSTR_VEC,
	input  wire logic                   CORE_NMI_DONE,
	output logic                        SYS_RESET_N,
	output logic                        CORE_TAKE,
	output logic      [5:0]             CORE_VEC,
	output logic      [2:0]             CORE_SRC,
	output logic      [15:0]            PLL_CTRL
);

	localparam int NF = NLINE * NSRC;

	rip_rst_if rs ();

	logic [NPIN-1:0]  s1_q, s2_q, s3_q, flt_q, prv_q;
	logic [NPIN-1:0]  fall;
	logic [NPIN-1:0]  pins_n;
	logic             active;
	logic             ack_q;
	logic [31:0]      dat_q;
	logic             wb_req, wr;
	logic [31:0]      wmask;
	logic             hit_ctl, hit_stat, hit_lm, hit_st0, hit_flag, hit_en, hit_pll, hit_irq;
	logic [31:0]      rd_data;
	logic [1:0]       ctl_q;
	logic [15:0]      cause_q, cause_set, cause_clr;
	logic [NLINE-1:0] lmask_q;
	logic             gmask_q;
	logic [NF-1:0]    flag_q, en_q, flag_clr, take_clr, pin_set, act_src;
	logic [15:0]      pll_q;
	logic             nmi_pend_q, nmi_busy_q;
	logic             take_q;
	logic [5:0]       vec_q;
	logic [2:0]       src_q;
	logic             rstn_q;
	logic             wd_evt, sw_evt;
	logic [NLINE-1:0] line_pend, line_req;
	logic             line_go, can, take_nmi, take_ins, take_ln, is_trap;
	logic [2:0]       sel_ln, sel_src;
	logic [NSRC-1:0]  src_vec;
	logic [5:0]       ln_vec, ins_vec;

	rip_rst_seq u_seq (
		.clk_sys (CLK_SYS),
		.rst_n   (RST_N),
		.clk_en  (CLK_EN),
		.rs      (rs.seq)
	);

	// Pins arrive from outside the clock domain and all idle high.
	assign pins_n = {DRIVE_PROTECT_IRQ_N, EXT_IRQ_THREE_N, EXT_IRQ_TWO_N, EXT_IRQ_ONE_N,
		NMI_PIN_N, POWER_ON_RESET_PIN_N, EXT_RESET_PIN_N_I};

	// Three stages; the filtered level moves only when stages two and three agree.
	for (genvar g = 0; g < NPIN; g++) begin : g_sync
		always_ff @(posedge CLK_SYS or negedge RST_N) begin
			if (!RST_N) begin
				s1_q[g]  <= 1'b1;
				s2_q[g]  <= 1'b1;
				s3_q[g]  <= 1'b1;
				flt_q[g] <= 1'b1;
				prv_q[g] <= 1'b1;
			end else if (CLK_EN) begin
				s1_q[g]  <= pins_n[g];
				s2_q[g]  <= s1_q[g];
				s3_q[g]  <= s2_q[g];
				flt_q[g] <= (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
				prv_q[g] <= flt_q[g];
			end
		end
	end
	assign fall = prv_q & ~flt_q;

	// RQ1: watchdog reset source
	assign wd_evt = WDOG_OVERFLOW | WDOG_BAD_WRITE;
	// RQ2: software reset bits
	assign sw_evt = hit_ctl & wr & ((wmask[SC_CLR] & ~WB_DAT_I[SC_CLR]) | (wmask[SC_SET] & WB_DAT_I[SC_SET]));
	// RQ3: illegal access reset
	assign rs.trig    = wd_evt | sw_evt | BAD_ADDR_ACCESS;
	// RQ7: pin levels hold reset
	assign rs.por_low = ~flt_q[PIN_POR];
	assign rs.pin_low = ~flt_q[PIN_RS];
	assign active     = rs.drive | rs.pin_low; // A pin held low from outside keeps reset on between stretches.

	// Bus decode; a request is taken in the cycle before ack.
	assign wb_req   = WB_CYC_I & WB_STB_I & ~ack_q;
	assign wr       = wb_req & WB_WE_I;
	assign wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	assign hit_ctl  = (WB_ADR_I == A_SYSCTL);
	assign hit_stat = (WB_ADR_I == A_SYSSTAT);
	assign hit_lm   = (WB_ADR_I == A_LMASK);
	assign hit_st0  = (WB_ADR_I == A_ST0);
	assign hit_flag = (WB_ADR_I == A_FLAG);
	assign hit_en   = (WB_ADR_I == A_EN);
	assign hit_pll  = (WB_ADR_I == A_PLL);
	assign hit_irq  = (WB_ADR_I == A_IRQST);
	// Unmapped addresses still ack, reading zero, so a stray access never hangs the bus.
	assign rd_data  = hit_ctl  ? {16'h0000, ctl_q, 14'h0000} :
	                  hit_stat ? {16'h0000, cause_q} :
	                  hit_lm   ? 32'(lmask_q) :
	                  hit_st0  ? (32'(gmask_q) << ST0_GMASK) :
	                  hit_flag ? 32'(flag_q) :
	                  hit_en   ? 32'(en_q) :
	                  hit_pll  ? {16'h0000, pll_q} :
	                  hit_irq  ? {16'h0000, 6'h00, line_pend, 2'h0, nmi_busy_q, nmi_pend_q} : 32'h00000000;

	// Bus answer registers.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else if (CLK_EN) begin
			ack_q <= wb_req;
			dat_q <= wb_req ? rd_data : dat_q;
		end
	end

	// RQ10: cause flag positions
	// RQ25: set on detection
	assign cause_set = (16'(rs.por_low) << CF_POR) | (16'(BAD_ADDR_ACCESS) << CF_BAD) |
	                   (16'(sw_evt) << CF_SW) | (16'(wd_evt) << CF_WD);
	assign cause_clr = (hit_stat & wr) ? (WB_DAT_I[15:0] & wmask[15:0]) : 16'h0000;

	// RQ23: flags and enables
	// RQ15: per event enable
	assign pin_set  = NF'({fall[PIN_PDP], 1'b0, fall[PIN_X3], fall[PIN_X2], fall[PIN_X1]});
	assign flag_clr = (hit_flag & wr) ? (WB_DAT_I[NF-1:0] & wmask[NF-1:0]) : '0;
	assign act_src  = flag_q & en_q;

	// RQ22: merge sources per line
	// RQ21: line ownership by slice
	for (genvar k = 0; k < NLINE; k++) begin : g_line
		assign line_pend[k] = |act_src[k*NSRC +: NSRC];
	end

	// RQ13: line mask gating
	assign line_req = line_pend & lmask_q;
	// RQ24: global mask blocks
	assign line_go  = (|line_req) & ~gmask_q;
	// RQ19: fixed rank arbitration
	assign sel_ln   = rip_first(8'(line_req));
	assign src_vec  = act_src[int'(sel_ln)*NSRC +: NSRC];
	assign sel_src  = rip_first(8'(src_vec));
	// RQ20: line vectors follow rank
	assign ln_vec   = VEC_LINE1 + {2'h0, sel_ln, 1'b0};

	// RQ14: nonmaskable lockout
	assign can      = CORE_READY & ~active;
	assign take_nmi = can & nmi_pend_q & ~nmi_busy_q;
	assign take_ins = can & ~take_nmi & CORE_INSTR_VALID & ~take_q; // The core drops valid only after it sees the take.
	assign take_ln  = can & ~take_nmi & ~CORE_INSTR_VALID & line_go;
	assign is_trap  = take_ins & (CORE_INSTR_OP == OP_TRAP);
	// RQ16: vector call operand
	// RQ17: nonmaskable vector
	// RQ18: trap vector
	assign ins_vec  = (CORE_INSTR_OP == OP_NMI) ? VEC_NMI :
	                  (CORE_INSTR_OP == OP_TRAP) ? VEC_TRAP : CORE_INSTR_VEC;
	assign take_clr = take_ln ? (NF'(1) << (int'(sel_ln) * NSRC + int'(sel_src))) : '0;

	// Control registers; the system reset reloads them, except the cause flags, and the PLL register only on power-on.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctl_q   <= CTL_RST;
			cause_q <= CAUSE_RST;
			lmask_q <= '0;
			gmask_q <= 1'b1;
			flag_q  <= '0;
			en_q    <= '0;
			pll_q   <= PLL_RST;
		end else if (CLK_EN) begin
			// RQ11: flags survive reset
			cause_q <= (cause_q & ~cause_clr) | cause_set;
			// RQ9: power-on clears PLL
			if (rs.por_act) begin
				pll_q <= PLL_RST;
			end else if (hit_pll & wr) begin
				pll_q <= (pll_q & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0]);
			end
			// RQ12: masks closed in reset
			// RQ8: restore control bits
			if (active) begin
				ctl_q   <= CTL_RST;
				lmask_q <= '0;
				gmask_q <= 1'b1;
				flag_q  <= '0;
				en_q    <= '0;
			end else begin
				if (hit_ctl & wr) begin
					ctl_q <= (ctl_q & ~wmask[15:14]) | (WB_DAT_I[15:14] & wmask[15:14]);
				end
				if (hit_lm & wr) begin
					lmask_q <= (lmask_q & ~wmask[NLINE-1:0]) | (WB_DAT_I[NLINE-1:0] & wmask[NLINE-1:0]);
				end
				if (hit_en & wr) begin
					en_q <= (en_q & ~wmask[NF-1:0]) | (WB_DAT_I[NF-1:0] & wmask[NF-1:0]);
				end
				// RQ24: set on take except trap
				if ((take_nmi | take_ins | take_ln) & ~is_trap) begin
					gmask_q <= 1'b1;
				end else if (hit_st0 & wr & wmask[ST0_GMASK]) begin
					gmask_q <= WB_DAT_I[ST0_GMASK];
				end
				// New requests win over a clear in the same cycle.
				flag_q <= (flag_q & ~flag_clr & ~take_clr) | PERIPH_IRQ | pin_set;
			end
		end
	end

	// Branch issue to the core and nonmaskable bookkeeping.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			nmi_pend_q <= 1'b0;
			nmi_busy_q <= 1'b0;
			take_q     <= 1'b0;
			vec_q      <= 6'h00;
			src_q      <= 3'h0;
			rstn_q     <= 1'b0;
		end else if (CLK_EN) begin
			rstn_q <= ~active;
			take_q <= take_nmi | take_ins | take_ln;
			if (take_nmi) begin
				vec_q <= VEC_NMI;
			end else if (take_ins) begin
				vec_q <= ins_vec;
			end else if (take_ln) begin
				vec_q <= ln_vec;
				src_q <= sel_src;
			end
			// RQ14: busy until return
			if (active) begin
				nmi_pend_q <= 1'b0;
				nmi_busy_q <= 1'b0;
			end else begin
				nmi_pend_q <= fall[PIN_NMI] | (nmi_pend_q & ~take_nmi);
				if (take_nmi | (take_ins & (CORE_INSTR_OP == OP_NMI))) begin
					nmi_busy_q <= 1'b1;
				end else if (CORE_NMI_DONE) begin
					nmi_busy_q <= 1'b0;
				end
			end
		end
	end

	// Every top-level output is a flip-flop.
	assign WB_ACK_O          = ack_q;
	assign WB_DAT_O          = dat_q;
	assign EXT_RESET_PIN_OE  = rs.drive;
	assign EXT_RESET_PIN_N_O = rs.pin_o;
	assign SYS_RESET_N       = rstn_q;
	assign CORE_TAKE         = take_q;
	assign CORE_VEC          = vec_q;
	assign CORE_SRC          = src_q;
	assign PLL_CTRL          = pll_q;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N || !CLK_EN);

	property p_wd;
		wd_evt |=> cause_q[CF_WD] ##1 !SYS_RESET_N;
	endproperty
	a_wd: assert property (p_wd) else $error("Watchdog event did not reset."); // RQ1

	property p_sw;
		sw_evt |-> ##2 !SYS_RESET_N && cause_q[CF_SW] && EXT_RESET_PIN_OE;
	endproperty
	a_sw: assert property (p_sw) else $error("Software reset write ignored."); // RQ2

	property p_bad;
		BAD_ADDR_ACCESS |=> cause_q[CF_BAD] && active;
	endproperty
	a_bad: assert property (p_bad) else $error("Illegal access did not reset."); // RQ3

	property p_keep;
		$fell(cause_q[CF_POR]) |-> $past(hit_stat & wr);
	endproperty
	a_keep: assert property (p_keep) else $error("Cause flag lost without software clear."); // RQ11

	property p_mask_after;
		$fell(SYS_RESET_N) |-> gmask_q && lmask_q == '0;
	endproperty
	a_mask_after: assert property (p_mask_after) else $error("Interrupts enabled during reset."); // RQ12

	property p_line_gate;
		take_ln |-> !gmask_q && lmask_q[sel_ln] && line_pend[sel_ln];
	endproperty
	a_line_gate: assert property (p_line_gate) else $error("Masked line was taken."); // RQ13

	property p_nmi_lock;
		(nmi_busy_q || active) && !CORE_INSTR_VALID |=> !(CORE_TAKE && CORE_VEC == VEC_NMI);
	endproperty
	a_nmi_lock: assert property (p_nmi_lock) else $error("Nonmaskable taken while locked."); // RQ14

	property p_nmi_vec;
		take_nmi |=> CORE_TAKE && CORE_VEC == VEC_NMI && gmask_q && nmi_busy_q;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("Nonmaskable branch wrong."); // RQ17

	property p_trap;
		is_trap && !(hit_st0 && wr) |=> CORE_VEC == VEC_TRAP && gmask_q == $past(gmask_q);
	endproperty
	a_trap: assert property (p_trap) else $error("Trap changed the global mask."); // RQ18

	property p_rank;
		can && nmi_pend_q && !nmi_busy_q && line_go |=> CORE_VEC == VEC_NMI;
	endproperty
	a_rank: assert property (p_rank) else $error("Maskable line beat nonmaskable."); // RQ19

	c_sw_reset: cover property (sw_evt ##2 !SYS_RESET_N);
	c_trap: cover property (is_trap);
	c_line: cover property (take_ln ##1 CORE_TAKE);
	c_nmi: cover property (take_nmi);

endmodule : rip_top

// ==== bench/rip_core_model.sv ====
`timescale 1ns/100ps
// Stand-in for the core and the board around the reset pin.
module rip_core_model
	import rip_pkg::*;
(
	// Clock, reset and bench commands.
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       ready_en,
	input  wire logic       ext_low,
	input  wire logic       go,
	input  wire logic [1:0] op,
	input  wire logic [5:0] vec,
	// What the block tells the core and the pin.
	input  wire logic       take,
	input  wire logic [5:0] take_vec,
	input  wire logic       pin_o,
	input  wire logic       pin_oe,
	// Core request lines and pin level.
	output logic            ready,
	output logic            ivalid,
	output logic [1:0]      iop,
	output logic [5:0]      ivec,
	output logic            nmi_done,
	output logic            pin_lvl
);
	logic [4:0] hcnt_q;

	// board pull low held for many cycles; the pull-up wins when nobody drives.
	assign pin_lvl = ~((pin_oe & ~pin_o) | ext_low);
	assign ready   = ready_en;

	// The request stays up until the take pulse; a nonmaskable handler ends 31 cycles later.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ivalid   <= 1'b0;
			iop      <= 2'h0;
			ivec     <= 6'h00;
			nmi_done <= 1'b0;
			hcnt_q   <= 5'h00;
		end else begin
			if (go) begin
				ivalid <= 1'b1;
				iop    <= op;
				ivec   <= vec;
			end else if (take) begin
				ivalid <= 1'b0;
			end
			nmi_done <= (hcnt_q == 5'h01);
			if (take && take_vec == VEC_NMI) hcnt_q <= 5'h1f;
			else if (hcnt_q != 5'h00) hcnt_q <= hcnt_q - 5'h01;
		end
	end
endmodule : rip_core_model

// ==== bench/tb_reset_and_interrupt_priority.sv ====
`timescale 1ns/100ps
// Drives the register bus, reset causes and interrupt requests, and checks the results.
module tb_reset_and_interrupt_priority;
	import rip_pkg::*;
	logic        clk, rst_n, cyc, stb, we, ack, oe, pin_o, pin_lvl, por_n;
	logic        wd_of, wd_bad, bad_a, nmi_n, xn, ready, ivalid, ndone, sys_rst_n, take;
	logic        ready_en, ext_low, go, h;
	logic [1:0]  iop, gop;
	logic [5:0]  ivec, gvec, cvec;
	logic [2:0]  csrc;
	logic [7:0]  adr;
	logic [15:0] pll;
	logic [29:0] periph;
	logic [31:0] dat_i, dat_o, r, exp_c;
	int          errors, total_checks, oc, hc;
	logic [1:0]  ops [3] = '{OP_TRAP, OP_VCALL, OP_NMI};
	logic [5:0]  evec [3] = '{VEC_TRAP, 6'h0a, VEC_NMI};

	rip_top rip_top_inst (.CLK_SYS(clk), .RST_N(rst_n), .CLK_EN(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.EXT_RESET_PIN_N_I(pin_lvl), .EXT_RESET_PIN_N_O(pin_o), .EXT_RESET_PIN_OE(oe),
		.POWER_ON_RESET_PIN_N(por_n), .WDOG_OVERFLOW(wd_of), .WDOG_BAD_WRITE(wd_bad),
		.BAD_ADDR_ACCESS(bad_a), .NMI_PIN_N(nmi_n), .EXT_IRQ_ONE_N(xn), .EXT_IRQ_TWO_N(xn),
		.EXT_IRQ_THREE_N(xn), .DRIVE_PROTECT_IRQ_N(xn), .PERIPH_IRQ(periph), .CORE_READY(ready),
		.CORE_INSTR_VALID(ivalid), .CORE_INSTR_OP(iop), .CORE_INSTR_VEC(ivec), .CORE_NMI_DONE(ndone),
		.SYS_RESET_N(sys_rst_n), .CORE_TAKE(take), .CORE_VEC(cvec), .CORE_SRC(csrc), .PLL_CTRL(pll));

	rip_core_model rip_core_model_inst (.clk_sys(clk), .rst_n(rst_n), .ready_en(ready_en), .ext_low(ext_low),
		.go(go), .op(gop), .vec(gvec), .take(take), .take_vec(cvec), .pin_o(pin_o), .pin_oe(oe),
		.ready(ready), .ivalid(ivalid), .iop(iop), .ivec(ivec), .nmi_done(ndone), .pin_lvl(pin_lvl));

	// Clock at 40 MHz.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Cycles of pin drive, counted in the background so a bus access cannot hide them.
	always @(posedge clk) begin
		if (oe === 1'b1) oc++;
	end

	// Compare one value; unknown bits never match.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Classic single cycle; the request holds until ack is sampled, then idles a cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		cyc   <= 1'b1;
		stb   <= 1'b1;
		we    <= w;
		adr   <= a;
		dat_i <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb

	// Wait a bounded time for a branch pulse.
	task automatic wait_take(input int lim, output logic hit);
		int n;
		n   = 0;
		hit = (take === 1'b1);
		while (!hit && n < lim) begin
			@(posedge clk);
			n++;
			hit = (take === 1'b1);
		end
	endtask : wait_take

	// Open the global mask, let the core accept, and check the branch.
	task automatic go_take(input logic [5:0] v, input logic [2:0] s, input logic cs);
		logic hit;
		wb(1'b1, A_ST0, 32'h0, r);
		ready_en <= 1'b1;
		wait_take(40, hit);
		ready_en <= 1'b0;
		chk("take", 32'(hit), 32'h1);
		chk("vec", 32'(cvec), 32'(v));
		if (cs) chk("src", 32'(csrc), 32'(s));
	endtask : go_take

	// Print the counts and the verdict, then stop.
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	// Hang guard: the sequence needs well under 3000 cycles.
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end

	// Main sequence.
	initial begin
		{rst_n, cyc, stb, we, wd_of, wd_bad, bad_a, ready_en, ext_low, go} = '0;
		{por_n, nmi_n, xn} = 3'h7;
		{adr, dat_i, periph, gop, gvec} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, A_SYSSTAT, 32'h0, r);
		chk("cause_init", r, 32'(CAUSE_RST));
		chk("pll_init", 32'(pll), 32'(PLL_RST));
		wb(1'b1, 8'h3c, 32'h0, r);
		wb(1'b0, A_SYSCTL, 32'h0, r);
		chk("ctl_init", r, 32'h4000);
		wb(1'b1, A_SYSSTAT, 32'hffff, r);
		wb(1'b0, A_SYSSTAT, 32'h0, r);
		chk("cause_clear", r, 32'h0);
		$display("test power_up done");
		// flags pile up across resets; only power-on clears the PLL.
		wb(1'b1, A_PLL, 32'h1234, r);
		exp_c = 32'h0;
		for (int k = 0; k < 6; k++) begin
			wb(1'b1, A_ST0, 32'h0, r);
			oc = 0;
			case (k)
				0: wd_of <= 1'b1;
				1: wd_bad <= 1'b1;
				2: bad_a <= 1'b1;
				3: wb(1'b1, A_SYSCTL, 32'hc000, r);
				4: wb(1'b1, A_SYSCTL, 32'h0000, r);
				default: por_n <= 1'b0;
			endcase
			exp_c |= 32'h1 << (k < 2 ? CF_WD : k == 2 ? CF_BAD : k < 5 ? CF_SW : CF_POR);
			repeat (3) @(posedge clk);
			{wd_of, wd_bad, bad_a, por_n} <= 4'h1;
			repeat (40) @(posedge clk);
			chk("drive_len", 32'(oc >= 8), 32'h1);
			wb(1'b0, A_SYSSTAT, 32'h0, r);
			chk("cause", r, exp_c);
			wb(1'b0, A_ST0, 32'h0, r);
			chk("gmask_rst", 32'(r[ST0_GMASK]), 32'h1);
			wb(1'b0, A_SYSCTL, 32'h0, r);
			chk("ctl_rst", r, 32'h4000);
			chk("pll", 32'(pll), k == 5 ? 32'h0 : 32'h1234);
		end
		$display("test reset_causes done");
		ext_low <= 1'b1;
		repeat (10) @(posedge clk);
		hc = 0;
		repeat (20) @(posedge clk) hc += (sys_rst_n === 1'b1);
		chk("held_low", hc, 0);
		ext_low <= 1'b0;
		repeat (30) @(posedge clk);
		chk("released", 32'(sys_rst_n), 32'h1);
		$display("test pin_hold done");
		// Line 1 sources 1 and 3, line 2 source 0, masked line 3 source 0.
		wb(1'b1, A_EN, 32'h42a, r);
		wb(1'b1, A_LMASK, 32'h3, r);
		periph <= 30'h42a;
		@(posedge clk);
		periph <= 30'h0;
		wb(1'b0, A_FLAG, 32'h0, r);
		chk("flags", r, 32'h42a);
		go_take(VEC_LINE1, 3'h1, 1'b1);
		wb(1'b0, A_ST0, 32'h0, r);
		chk("gmask_take", 32'(r[ST0_GMASK]), 32'h1);
		go_take(VEC_LINE1, 3'h3, 1'b1);
		go_take(6'h04, 3'h0, 1'b1);
		wb(1'b1, A_ST0, 32'h0, r);
		ready_en <= 1'b1;
		wait_take(12, h);
		ready_en <= 1'b0;
		chk("masked_line", 32'(h), 32'h0);
		$display("test lines done");
		for (int k = 0; k < 3; k++) begin
			gop  <= ops[k];
			gvec <= 6'h0a;
			go   <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			go_take(evec[k], 3'h0, 1'b0);
			wb(1'b0, A_ST0, 32'h0, r);
			chk("gmask_instr", 32'(r[ST0_GMASK]), 32'(k != 0));
		end
		nmi_n    <= 1'b0;
		ready_en <= 1'b1;
		wait_take(12, h);
		chk("nmi_busy", 32'(h), 32'h0);
		wait_take(60, h);
		chk("nmi_pin", 32'({h, cvec}), 32'({1'b1, VEC_NMI}));
		ready_en <= 1'b0;
		nmi_n    <= 1'b1;
		$display("test instructions done");
		wb(1'b1, A_EN, 32'h0, r);
		wb(1'b1, A_ST0, 32'h0, r);
		xn       <= 1'b0;
		ready_en <= 1'b1;
		wait_take(12, h);
		ready_en <= 1'b0;
		xn       <= 1'b1;
		chk("ext_disabled", 32'(h), 32'h0);
		wb(1'b0, A_FLAG, 32'h0, r);
		chk("ext_flags", r, 32'h417);
		wb(1'b1, A_EN, 32'h1, r);
		go_take(VEC_LINE1, 3'h0, 1'b1);
		$display("test ext_pins done");
		close_out();
	end
endmodule : tb_reset_and_interrupt_priority
